// ### design/cudc_defs.svh
// Register offsets, field positions, reset values and timing counts for the console serial port
// =====================================================================
`ifndef CUDC_DEFS_SVH
`define CUDC_DEFS_SVH
`define CUDC_OFS_DATA 2'h0
`define CUDC_OFS_IER 2'h1
`define CUDC_OFS_FCR 2'h2
`define CUDC_OFS_LCR 2'h3
`define CUDC_LCR_DLAB 7
`define CUDC_LCR_RST 8'h00
`define CUDC_IER_RST 8'h00
`define CUDC_FCR_RST 8'h00
`define CUDC_DIV_RST 16'h0001
`define CUDC_OVERSAMPLE 16
`define CUDC_MID_TICK 4'h7
`define CUDC_IER_RX 0
`define CUDC_IER_TX 1
`define CUDC_FCR_RXCLR 1
`define CUDC_FCR_TXCLR 2
`define CUDC_BASE_A 32'hbfe001e0
`define CUDC_BASE_B 32'hbfe001e8
`define CUDC_BASE_LPC 32'hbff003f8
`endif

// ### design/cudc_pkg.sv
// Types shared by the console serial port
package cudc_pkg;
	typedef struct packed {
		logic [1:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} cudc_req_t;
	typedef enum logic [1:0] {CUDC_IDLE, CUDC_START, CUDC_DATA, CUDC_STOP} cudc_state_t;
endpackage : cudc_pkg

// ### design/cudc_bit_timer.sv
// Sixteen-times oversample tick generator
`timescale 1ns/1ps
module cudc_bit_timer (
	input wire logic clk_in, // Working clock
	input wire logic reset_in, // Asynchronous reset, active high
	input wire logic [15:0] divisor_in, // Programmed divisor
	output logic tick_out // One pulse per oversample period
);
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	wire logic reload = (count_r <= 16'h0001);
	// A divisor of zero is treated as one so the port never stalls
	assign count_nxt = reload ? ((divisor_in == 16'h0000) ? 16'h0001 : divisor_in)
		: count_r - 16'h0001;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			count_r <= 16'h0001;
			tick_out <= 1'b0;
		end else begin
			count_r <= count_nxt;
			tick_out <= reload;
		end
	end
endmodule : cudc_bit_timer

// ### design/cudc_uart.sv
// Console serial port: byte registers, transmitter and receiver
`timescale 1ns/1ps
`include "cudc_defs.svh"
module cudc_uart import cudc_pkg::*; (
	input wire logic clk_in, // Working clock
	input wire logic reset_in, // Asynchronous reset, active high
	input wire cudc_req_t req_in, // Byte register access
	output logic [7:0] rdata_out, // Read data, valid cycle after rd
	input wire logic rx_in, // Serial line in
	output logic tx_out, // Serial line out
	output logic irq_out, // Interrupt request
	output logic [7:0] fifo_ctrl_out // Last FIFO control value
);
	// =====================================================================
	// Registers
	logic [7:0] lcr_r, ier_r, fcr_r, div_lo_r, div_hi_r, rx_data_r;
	logic rx_full_r, tx_busy_r;
	wire logic dlab = lcr_r[`CUDC_LCR_DLAB];
	wire logic wr_data = req_in.wr && req_in.addr == `CUDC_OFS_DATA;
	wire logic wr_ier = req_in.wr && req_in.addr == `CUDC_OFS_IER;
	wire logic dll_we = wr_data && dlab;
	wire logic dlm_we = wr_ier && dlab;
	wire logic ier_we = wr_ier && !dlab;
	wire logic tx_we = wr_data && !dlab;
	wire logic fcr_we = req_in.wr && req_in.addr == `CUDC_OFS_FCR;
	wire logic lcr_we = req_in.wr && req_in.addr == `CUDC_OFS_LCR;
	wire logic rx_rd = req_in.rd && req_in.addr == `CUDC_OFS_DATA && !dlab;
	wire logic [15:0] divisor = {div_hi_r, div_lo_r};
	logic [7:0] rd_mux;
	always_comb begin
		unique case (req_in.addr)
			`CUDC_OFS_DATA: rd_mux = dlab ? div_lo_r : rx_data_r;
			`CUDC_OFS_IER: rd_mux = dlab ? div_hi_r : ier_r;
			`CUDC_OFS_FCR: rd_mux = {6'h00, tx_busy_r, rx_full_r};
			`CUDC_OFS_LCR: rd_mux = lcr_r;
		endcase
	end
	logic rx_done;
	logic [7:0] rx_byte;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			lcr_r <= `CUDC_LCR_RST;
			ier_r <= `CUDC_IER_RST;
			fcr_r <= `CUDC_FCR_RST;
			{div_hi_r, div_lo_r} <= `CUDC_DIV_RST;
			rdata_out <= 8'h00;
		end else begin
			if (lcr_we) lcr_r <= req_in.wdata;
			if (ier_we) ier_r <= req_in.wdata;
			if (fcr_we) fcr_r <= req_in.wdata;
			if (dll_we) div_lo_r <= req_in.wdata;
			if (dlm_we) div_hi_r <= req_in.wdata;
			if (req_in.rd) rdata_out <= rd_mux;
		end
	end
	assign fifo_ctrl_out = fcr_r;
	// Zero in interrupt enable masks every source
	assign irq_out = (ier_r[`CUDC_IER_RX] && rx_full_r) ||
		(ier_r[`CUDC_IER_TX] && !tx_busy_r);
	// =====================================================================
	// Oversample tick
	logic tick;
	cudc_bit_timer u_timer (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.divisor_in(divisor),
		.tick_out(tick)
	);
	// =====================================================================
	// Transmitter: start, eight data LSB first, one stop, no parity
	cudc_state_t tx_st_r;
	logic [3:0] tx_sub_r;
	logic [2:0] tx_bit_r;
	logic [7:0] tx_sh_r;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			tx_st_r <= CUDC_IDLE;
			tx_sub_r <= 4'h0;
			tx_bit_r <= 3'h0;
			tx_sh_r <= 8'h00;
			tx_out <= 1'b1;
			tx_busy_r <= 1'b0;
		end else begin
			unique case (tx_st_r)
				CUDC_IDLE: begin
					tx_out <= 1'b1;
					// Writes while busy are dropped: there is no holding buffer
					if (tx_we) begin
						tx_sh_r <= req_in.wdata;
						tx_busy_r <= 1'b1;
						tx_sub_r <= 4'h0;
						tx_st_r <= CUDC_START;
					end
				end
				CUDC_START: begin
					tx_out <= 1'b0;
					if (tick) begin
						tx_sub_r <= tx_sub_r + 4'h1;
						if (tx_sub_r == 4'hf) begin
							tx_st_r <= CUDC_DATA;
							tx_bit_r <= 3'h0;
						end
					end
				end
				CUDC_DATA: begin
					tx_out <= tx_sh_r[0];
					if (tick) begin
						tx_sub_r <= tx_sub_r + 4'h1;
						if (tx_sub_r == 4'hf) begin
							tx_sh_r <= {1'b0, tx_sh_r[7:1]};
							tx_bit_r <= tx_bit_r + 3'h1;
							if (tx_bit_r == 3'h7) tx_st_r <= CUDC_STOP;
						end
					end
				end
				CUDC_STOP: begin
					tx_out <= 1'b1;
					if (tick) begin
						tx_sub_r <= tx_sub_r + 4'h1;
						if (tx_sub_r == 4'hf) begin
							tx_st_r <= CUDC_IDLE;
							tx_busy_r <= 1'b0;
						end
					end
				end
			endcase
		end
	end
	// =====================================================================
	// Receiver line synchroniser
	logic rx_s1_r, rx_s2_r;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
		end else begin
			rx_s1_r <= rx_in;
			rx_s2_r <= rx_s1_r;
		end
	end
	// =====================================================================
	// Receiver: mid-bit sampling at sixteen ticks per bit
	cudc_state_t rx_st_r;
	logic [3:0] rx_sub_r;
	logic [2:0] rx_bit_r;
	logic [7:0] rx_sh_r;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rx_st_r <= CUDC_IDLE;
			rx_sub_r <= 4'h0;
			rx_bit_r <= 3'h0;
			rx_sh_r <= 8'h00;
			rx_done <= 1'b0;
			rx_byte <= 8'h00;
		end else begin
			rx_done <= 1'b0;
			unique case (rx_st_r)
				CUDC_IDLE: begin
					rx_sub_r <= 4'h0;
					if (!rx_s2_r) rx_st_r <= CUDC_START;
				end
				CUDC_START: begin
					if (tick) begin
						rx_sub_r <= rx_sub_r + 4'h1;
						// Recheck at mid start bit to reject glitches
						if (rx_sub_r == `CUDC_MID_TICK) begin
							rx_sub_r <= 4'h0;
							rx_bit_r <= 3'h0;
							rx_st_r <= rx_s2_r ? CUDC_IDLE : CUDC_DATA;
						end
					end
				end
				CUDC_DATA: begin
					if (tick) begin
						rx_sub_r <= rx_sub_r + 4'h1;
						if (rx_sub_r == 4'hf) begin
							rx_sh_r <= {rx_s2_r, rx_sh_r[7:1]};
							rx_bit_r <= rx_bit_r + 3'h1;
							if (rx_bit_r == 3'h7) rx_st_r <= CUDC_STOP;
						end
					end
				end
				CUDC_STOP: begin
					if (tick) begin
						rx_sub_r <= rx_sub_r + 4'h1;
						if (rx_sub_r == 4'hf) begin
							rx_st_r <= CUDC_IDLE;
							// A bad stop bit discards the character
							if (rx_s2_r) begin
								rx_done <= 1'b1;
								rx_byte <= rx_sh_r;
							end
						end
					end
				end
			endcase
		end
	end
	// =====================================================================
	// Received byte holding; a new arrival wins over a same-cycle read
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rx_data_r <= 8'h00;
			rx_full_r <= 1'b0;
		end else if (rx_done) begin
			rx_data_r <= rx_byte;
			rx_full_r <= 1'b1;
		end else if (rx_rd || (fcr_we && req_in.wdata[`CUDC_FCR_RXCLR])) begin
			rx_full_r <= 1'b0;
		end
	end
endmodule : cudc_uart

// ### test/cudc_uart_asserts.sv
// Port checks for the console serial port
`timescale 1ns/1ps
module cudc_uart_asserts import cudc_pkg::*; (
	input wire logic clk_in, // Clock
	input wire logic reset_in, // Reset
	input wire cudc_req_t req_in, // Access
	input wire logic [7:0] rdata_out, // Read data
	input wire logic rx_in, // Line in
	input wire logic tx_out, // Line out
	input wire logic irq_out, // Request
	input wire logic [7:0] fifo_ctrl_out // FIFO control
);
	// Shadow copies let each readback be tied to the write that caused it
	logic [7:0] lcr_r;
	logic [7:0] ier_r;
	logic [15:0] div_r;
	wire logic dlab = lcr_r[7];
	wire logic [1:0] a = req_in.addr;
	wire logic w = req_in.wr;
	wire logic r = req_in.rd;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			lcr_r <= 8'h00;
			ier_r <= 8'h00;
			div_r <= 16'h0001;
		end else if (w) begin
			if (a == 2'h3) lcr_r <= req_in.wdata;
			if (a == 2'h1 && !dlab) ier_r <= req_in.wdata;
			if (a == 2'h0 && dlab) div_r[7:0] <= req_in.wdata;
			if (a == 2'h1 && dlab) div_r[15:8] <= req_in.wdata;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	property p_lcr; r && a == 2'h3 |=> rdata_out == $past(lcr_r); endproperty
	a_lcr: assert property (p_lcr) else $error("lcr read");
	property p_dlo; r && a == 2'h0 && dlab |=> rdata_out == $past(div_r[7:0]); endproperty
	a_dlo: assert property (p_dlo) else $error("div low");
	property p_dhi; r && a == 2'h1 && dlab |=> rdata_out == $past(div_r[15:8]); endproperty
	a_dhi: assert property (p_dhi) else $error("div high");
	property p_ier; r && a == 2'h1 && !dlab |=> rdata_out == $past(ier_r); endproperty
	a_ier: assert property (p_ier) else $error("ier read");
	property p_irq; ier_r == 8'h00 |-> !irq_out; endproperty
	a_irq: assert property (p_irq) else $error("irq masked");
	property p_fcr; w && a == 2'h2 |=> fifo_ctrl_out == $past(req_in.wdata); endproperty
	a_fcr: assert property (p_fcr) else $error("fcr write");
	property p_fhold; !(w && a == 2'h2) |=> $stable(fifo_ctrl_out); endproperty
	a_fhold: assert property (p_fhold) else $error("fcr hold");
	property p_rhold; !r [*2] |-> $stable(rdata_out); endproperty
	a_rhold: assert property (p_rhold) else $error("rdata hold");
endmodule : cudc_uart_asserts
bind cudc_uart cudc_uart_asserts i_chk (.clk_in(clk_in), .reset_in(reset_in), .req_in(req_in),
	.rdata_out(rdata_out), .rx_in(rx_in), .tx_out(tx_out), .irq_out(irq_out),
	.fifo_ctrl_out(fifo_ctrl_out));

// ### test/cudc_term.sv
// Remote terminal model: sends and decodes 8N1 frames
`timescale 1ns/1ps
module cudc_term #(
	parameter int BIT_CYC = 288
) (
	input wire logic clk_in, // Clock
	input wire logic tx_in, // Port line out
	output logic rx_out, // Port line in
	output logic [7:0] got_out // Last byte decoded
);
	initial rx_out = 1'b1;
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx_out <= f[i];
			repeat (BIT_CYC) @(posedge clk_in);
		end
	endtask : send_byte
	// Samples mid-bit, LSB first
	always begin
		@(negedge tx_in);
		repeat (BIT_CYC / 2) @(posedge clk_in);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge clk_in);
			got_out[i] <= tx_in;
		end
	end
endmodule : cudc_term

// ### test/console_uart_divisor_config_tb.sv
// Self-checking bench for the console serial port
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module console_uart_divisor_config_tb;
	import cudc_pkg::*;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	cudc_req_t req = '0;
	logic [7:0] rdata;
	logic [7:0] fcr;
	logic [7:0] got;
	logic rx;
	logic tx;
	logic irq;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	initial forever #2.5 clk_in = ~clk_in;
	cudc_uart i_dut (.clk_in(clk_in), .reset_in(reset_in), .req_in(req), .rdata_out(rdata),
		.rx_in(rx), .tx_out(tx), .irq_out(irq), .fifo_ctrl_out(fcr));
	// Divisor 0x12 gives 16 * 18 cycles per bit
	cudc_term #(.BIT_CYC(288)) i_term (.clk_in(clk_in), .tx_in(tx), .rx_out(rx), .got_out(got));
	task automatic acc(input logic [1:0] a, input logic w, input logic [7:0] d);
		@(posedge clk_in);
		req <= '{addr: a, wr: w, rd: !w, wdata: d};
		@(posedge clk_in);
		req <= '0;
	endtask : acc
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		acc(a, 1'b0, 8'h00);
		@(negedge clk_in);
		`CHK(rdata, e)
	endtask : rd
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 10000) begin
			num_errors++;
			final_report();
		end
	end
	initial begin
		repeat (20) @(posedge clk_in);
		reset_in <= 1'b0;
		@(negedge clk_in);
		`CHK({tx, irq, fcr}, 10'h200)
		$display("reset test done");
		acc(2'h3, 1'b1, 8'h80);
		acc(2'h0, 1'b1, 8'h12);
		acc(2'h1, 1'b1, 8'ha5);
		rd(2'h0, 8'h12);
		rd(2'h1, 8'ha5);
		rd(2'h3, 8'h80);
		acc(2'h1, 1'b1, 8'h00);
		acc(2'h3, 1'b1, 8'h03);
		acc(2'h1, 1'b1, 8'h03);
		rd(2'h1, 8'h03);
		`CHK(irq, 1'b1)
		acc(2'h1, 1'b1, 8'h00);
		acc(2'h2, 1'b1, 8'h47);
		@(negedge clk_in);
		`CHK({irq, fcr}, 9'h047)
		acc(2'h3, 1'b1, 8'h80);
		rd(2'h0, 8'h12);
		rd(2'h1, 8'h00);
		acc(2'h3, 1'b1, 8'h03);
		$display("register test done");
		acc(2'h0, 1'b1, 8'h5a);
		repeat (2900) @(posedge clk_in);
		`CHK({tx, got}, 9'h15a)
		i_term.send_byte(8'hc3);
		rd(2'h2, 8'h01);
		rd(2'h0, 8'hc3);
		rd(2'h2, 8'h00);
		$display("line test done");
		final_report();
	end
endmodule : console_uart_divisor_config_tb
